// >>> shared/rfs_pkg.sv
`default_nettype none
package rfs_pkg;

  // Counter slots
  localparam int NUM_CNT   = 9;
  localparam int IDX_LARGE = 0;
  localparam int IDX_UNDER = 1;
  localparam int IDX_OVER  = 2;
  localparam int IDX_JAB   = 3;
  localparam int IDX_FCS   = 4;
  localparam int IDX_LEN   = 5;
  localparam int IDX_SYM   = 6;
  localparam int IDX_ALIGN = 7;
  localparam int IDX_RES   = 8;

  // Register byte addresses
  localparam logic [31:0] ADDR_CFG = 32'h40034000;
  localparam logic [31:0] CNT_ADDR [NUM_CNT] = '{
    32'h40034180, 32'h40034184, 32'h40034188, 32'h4003418c, 32'h40034190,
    32'h40034194, 32'h40034198, 32'h4003419c, 32'h400341a0};

  // Counter field widths
  localparam int SMALL_W = 10;
  localparam int RES_W   = 18;
  localparam int LARGE_W = 32;

  // Configuration fields
  localparam int          CFG_FD_BIT     = 1;
  localparam int          CFG_JUMBO_BIT  = 3;
  localparam int          CFG_BIG_BIT    = 8;
  localparam int          CFG_LENCHK_BIT = 16;
  localparam int          CFG_IGNFCS_BIT = 26;
  localparam logic [31:0] CFG_MASK       = 32'h0401010a;
  localparam logic [31:0] CFG_RESET      = 32'h00000000;

  // Frame length limits in bytes
  localparam logic [13:0] MIN_LEN   = 14'h0040;
  localparam logic [13:0] STD_MAX   = 14'h05ee;
  localparam logic [13:0] BIG_MAX   = 14'h0600;
  localparam logic [13:0] LARGE_MIN = 14'h05ef;
  localparam logic [13:0] HDR_FCS   = 14'h0012;
  localparam logic [15:0] TYPE_MIN  = 16'h0600;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [13:0] len;
    logic [15:0] len_field;
    logic        dribble;
    logic        crc_bad;
    logic        pause;
    logic        copied;
  } rfs_frame_s;

  typedef struct packed {
    logic full_dup;
    logic jumbo;
    logic big;
    logic len_check;
    logic ign_fcs;
  } rfs_cfg_s;

  function automatic int cnt_width(input int idx);
    cnt_width = (idx == IDX_LARGE) ? LARGE_W : (idx == IDX_RES) ? RES_W : SMALL_W;
  endfunction

endpackage
`default_nettype wire

// >>> src/rfs_sat_counter.sv
`timescale 1ns/10ps
`default_nettype none
module rfs_sat_counter
#(
  parameter int W = 10
)
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Control
  input  wire logic         inc_i,
  input  wire logic         clr_i,
  // Value
  output logic [W-1:0]      count_o
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;
  wire  logic   at_max;

  assign at_max     = &count_reg;
  // Read clears, a coincident event still counts
  assign count_next = clr_i ? W'(inc_i) :
                      (inc_i && !at_max) ? count_reg + 1'b1 : count_reg;
  assign count_o    = count_reg;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_reg <= '0;
    else
      count_reg <= count_next;
  end

  sat_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (at_max && !clr_i) |=> (&count_reg))
    else $error("counter wrapped past its maximum");

  clr_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    clr_i |=> (count_reg == W'($past(inc_i))))
    else $error("counter not cleared by read");

endmodule
`default_nettype wire

// >>> src/rfs_frame_classify.sv
`timescale 1ns/10ps
`default_nettype none
module rfs_frame_classify
  import rfs_pkg::*;
#(
  parameter logic [13:0] JUMBO_MAX = 14'h2800
)
(
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Frame status at frame end
  input  wire logic             done_i,
  input  wire rfs_frame_s       frame_i,
  input  wire logic             sym_i,
  input  wire rfs_cfg_s         cfg_i,
  // One-cycle increments
  output logic [NUM_CNT-1:0]    inc_o
);

  wire logic [13:0]        max_len;
  wire logic [13:0]        large_max;
  wire logic [13:0]        payload;
  wire logic               over;
  wire logic               valid_len;
  wire logic               bad;
  wire logic [NUM_CNT-1:0] inc_next;

  assign max_len   = cfg_i.big ? BIG_MAX : STD_MAX;
  assign large_max = cfg_i.jumbo ? JUMBO_MAX : max_len;
  assign payload   = (frame_i.len > HDR_FCS) ? frame_i.len - HDR_FCS : 14'h0000;
  assign over      = frame_i.len > max_len;
  assign valid_len = !over && (frame_i.len >= MIN_LEN);
  assign bad       = frame_i.crc_bad || sym_i;

  assign inc_next[IDX_LARGE] = !bad && !frame_i.pause && frame_i.copied &&
                               frame_i.len >= LARGE_MIN && frame_i.len <= large_max;
  assign inc_next[IDX_UNDER] = cfg_i.full_dup && frame_i.len < MIN_LEN &&
                               !frame_i.crc_bad;
  assign inc_next[IDX_OVER]  = over && !bad;
  assign inc_next[IDX_JAB]   = over && bad;
  // Ignore-FCS mode does not stop this count
  assign inc_next[IDX_FCS]   = valid_len && !frame_i.dribble && bad;
  assign inc_next[IDX_LEN]   = cfg_i.len_check && frame_i.len_field < TYPE_MIN &&
                               !over && {2'h0, payload} < frame_i.len_field;
  assign inc_next[IDX_SYM]   = sym_i;
  assign inc_next[IDX_ALIGN] = valid_len && frame_i.dribble && bad;
  assign inc_next[IDX_RES]   = valid_len && frame_i.dribble && bad;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      inc_o <= '0;
    else
      inc_o <= done_i ? inc_next : '0;
  end

  large_cnt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_i && (frame_i.pause || !frame_i.copied)) |=> !inc_o[IDX_LARGE])
    else $error("large count on pause or dropped frame");

  under_cnt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_i && cfg_i.full_dup && frame_i.len < 14'h0040 && !frame_i.crc_bad)
    |=> inc_o[IDX_UNDER])
    else $error("undersize frame not counted");

  over_jab_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_i && frame_i.len > (cfg_i.big ? 14'h0600 : 14'h05ee))
    |=> (inc_o[IDX_OVER] != inc_o[IDX_JAB]))
    else $error("long frame not split into oversize or jabber");

  fcs_ign_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_i && cfg_i.ign_fcs && frame_i.crc_bad && !frame_i.dribble
     && frame_i.len >= 14'h0040 && frame_i.len <= 14'h05ee) |=> inc_o[IDX_FCS])
    else $error("bad crc frame missed by fcs count");

  len_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_i && (!cfg_i.len_check || frame_i.len_field >= 16'h0600)) |=> !inc_o[IDX_LEN])
    else $error("length error counted while not allowed");

  sym_cnt_a: assert property (@(posedge clk_i) disable iff (rst_i)
    done_i |=> (inc_o[IDX_SYM] == $past(sym_i)))
    else $error("symbol count mismatch");

  res_align_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (done_i && frame_i.dribble && frame_i.crc_bad && frame_i.len >= 14'h0040
     && frame_i.len <= (cfg_i.big ? 14'h0600 : 14'h05ee))
    |=> (inc_o[IDX_RES] && inc_o[IDX_ALIGN]))
    else $error("resource and alignment counts diverge");

endmodule
`default_nettype wire

// >>> src/rfs_rx_stats.sv
// Notes on behaviour
// - Count good copied non-pause frames of 1519+ bytes
// - Large ceiling: bit 8 1536, bit 3 jumbo
// - Undersize: full duplex, under 64, no CRC/alignment
// - Oversize: too long, no CRC/alignment/symbol error
// - Jabber: too long with CRC/alignment/symbol error
// - FCS: whole bytes, bad CRC, 64 to max
// - FCS also counts valid whole-byte symbol frames
// - FCS counts even under ignore-FCS mode
// - Length error: measured shorter than length field
// - Length check needs field below 0x0600, enable
// - Symbol count: receive-error seen during frame
// - Symbol frames of 64+ bytes also count FCS/alignment or jabber
// - Alignment: odd bits, bad CRC, valid length
// - Resource count uses alignment criteria
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module rfs_rx_stats
  import rfs_pkg::*;
#(
  parameter logic [13:0] JUMBO_MAX = 14'h2800
)
(
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // AXI4-Lite write address
  input  wire logic [31:0]  s_axi_awaddr_i,
  input  wire logic         s_axi_awvalid_i,
  output logic              s_axi_awready_o,
  // AXI4-Lite write data
  input  wire logic [31:0]  s_axi_wdata_i,
  input  wire logic [3:0]   s_axi_wstrb_i,
  input  wire logic         s_axi_wvalid_i,
  output logic              s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0]        s_axi_bresp_o,
  output logic              s_axi_bvalid_o,
  input  wire logic         s_axi_bready_i,
  // AXI4-Lite read address
  input  wire logic [31:0]  s_axi_araddr_i,
  input  wire logic         s_axi_arvalid_i,
  output logic              s_axi_arready_o,
  // AXI4-Lite read data
  output logic [31:0]       s_axi_rdata_o,
  output logic [1:0]        s_axi_rresp_o,
  output logic              s_axi_rvalid_o,
  input  wire logic         s_axi_rready_i,
  // Receive datapath status
  input  wire logic         frame_active_i,
  input  wire logic         frame_done_i,
  input  wire rfs_frame_s   frame_info_i,
  // PHY pin
  input  wire logic         phy_receive_error_input_i
);

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } rfs_rd_e;

  // Address match helper
  function automatic logic addr_is(input logic [31:0] a, input logic [31:0] b);
    addr_is = (a[31:2] == b[31:2]);
  endfunction

  // Write channel state
  logic         awready_reg;
  logic         wready_reg;
  logic         aw_have_reg;
  logic         w_have_reg;
  logic [31:0]  awaddr_reg;
  logic [31:0]  wdata_reg;
  logic [3:0]   wstrb_reg;
  logic         bvalid_reg;
  logic [1:0]   bresp_reg;
  logic [31:0]  cfg_reg;
  logic [31:0]  cfg_next;

  // Read channel state
  rfs_rd_e      rd_state_reg;
  logic [31:0]  rdata_reg;
  logic [1:0]   rresp_reg;

  // Symbol error capture
  logic         rxer_meta_reg;
  logic         rxer_sync_reg;
  logic         sym_seen_reg;

  wire logic         aw_fire;
  wire logic         w_fire;
  wire logic         aw_got;
  wire logic         w_got;
  wire logic         wr_go;
  wire logic         b_fire;
  wire logic [31:0]  wr_addr;
  wire logic [31:0]  wr_data;
  wire logic [3:0]   wr_strb;
  wire logic         wr_cfg_hit;
  wire logic [31:0]  strb_mask;
  wire logic         ar_fire;
  wire logic         r_fire;
  wire logic         rd_cfg_hit;
  wire logic         rd_any_hit;
  wire logic [31:0]  rd_mux;
  wire logic         sym_now;
  wire rfs_cfg_s     cfg;
  wire logic [NUM_CNT-1:0] inc;
  wire logic [NUM_CNT-1:0] rd_hit;
  wire logic [31:0]        cnt_val [NUM_CNT];
  logic [31:0]             cnt_sel;

  // Outputs straight from flops
  assign s_axi_awready_o = awready_reg;
  assign s_axi_wready_o  = wready_reg;
  assign s_axi_bvalid_o  = bvalid_reg;
  assign s_axi_bresp_o   = bresp_reg;
  assign s_axi_arready_o = rd_state_reg[0];
  assign s_axi_rvalid_o  = rd_state_reg[1];
  assign s_axi_rdata_o   = rdata_reg;
  assign s_axi_rresp_o   = rresp_reg;

  // Write decode
  assign aw_fire    = s_axi_awvalid_i && awready_reg;
  assign w_fire     = s_axi_wvalid_i && wready_reg;
  assign aw_got     = aw_have_reg || aw_fire;
  assign w_got      = w_have_reg || w_fire;
  assign wr_go      = aw_got && w_got && !bvalid_reg;
  assign b_fire     = bvalid_reg && s_axi_bready_i;
  assign wr_addr    = aw_have_reg ? awaddr_reg : s_axi_awaddr_i;
  assign wr_data    = w_have_reg ? wdata_reg : s_axi_wdata_i;
  assign wr_strb    = w_have_reg ? wstrb_reg : s_axi_wstrb_i;
  assign wr_cfg_hit = addr_is(wr_addr, ADDR_CFG);
  assign strb_mask  = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign cfg_next   = ((cfg_reg & ~strb_mask) | (wr_data & strb_mask)) & CFG_MASK;

  // Configuration fields steering the classifier
  assign cfg.full_dup  = cfg_reg[CFG_FD_BIT];
  assign cfg.jumbo     = cfg_reg[CFG_JUMBO_BIT];
  assign cfg.big       = cfg_reg[CFG_BIG_BIT];
  assign cfg.len_check = cfg_reg[CFG_LENCHK_BIT];
  assign cfg.ign_fcs   = cfg_reg[CFG_IGNFCS_BIT];

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
      cfg_reg     <= CFG_RESET;
    end
    else if (wr_go)
    begin
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      bvalid_reg  <= 1'b1;
      bresp_reg   <= wr_cfg_hit ? RESP_OKAY : RESP_SLVERR;
      if (wr_cfg_hit)
        cfg_reg <= cfg_next;
    end
    else if (b_fire)
    begin
      bvalid_reg  <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
    end
    // Both channels stay shut while the answer waits
    else if (!bvalid_reg)
    begin
      aw_have_reg <= aw_got;
      w_have_reg  <= w_got;
      awready_reg <= !aw_got;
      wready_reg  <= !w_got;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (aw_fire)
      awaddr_reg <= s_axi_awaddr_i;
    if (w_fire)
    begin
      wdata_reg <= s_axi_wdata_i;
      wstrb_reg <= s_axi_wstrb_i;
    end
  end

  // Read decode
  assign ar_fire    = s_axi_arvalid_i && rd_state_reg[0];
  assign r_fire     = rd_state_reg[1] && s_axi_rready_i;
  assign rd_cfg_hit = addr_is(s_axi_araddr_i, ADDR_CFG);
  assign rd_any_hit = rd_cfg_hit || (|rd_hit);
  assign rd_mux     = rd_cfg_hit ? cfg_reg : cnt_sel;

  always_comb
  begin
    cnt_sel = 32'h00000000;
    for (int i = 0; i < NUM_CNT; i++)
      if (rd_hit[i])
        cnt_sel = cnt_val[i];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_state_reg <= RD_IDLE;
      rdata_reg    <= 32'h00000000;
      rresp_reg    <= RESP_OKAY;
    end
    else
    begin
      case (rd_state_reg)
        RD_IDLE:
          if (ar_fire)
          begin
            rd_state_reg <= RD_RESP;
            rdata_reg    <= rd_mux;
            rresp_reg    <= rd_any_hit ? RESP_OKAY : RESP_SLVERR;
          end
        RD_RESP:
          if (r_fire)
            rd_state_reg <= RD_IDLE;
        default:
          rd_state_reg <= RD_IDLE;
      endcase
    end
  end

  // Receive-error pin synchroniser and per-frame capture
  assign sym_now = sym_seen_reg || (rxer_sync_reg && frame_active_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rxer_meta_reg <= 1'b0;
      rxer_sync_reg <= 1'b0;
      sym_seen_reg  <= 1'b0;
    end
    else
    begin
      rxer_meta_reg <= phy_receive_error_input_i;
      rxer_sync_reg <= rxer_meta_reg;
      sym_seen_reg  <= frame_done_i ? 1'b0 : sym_now;
    end
  end

  rfs_frame_classify #(
    .JUMBO_MAX (JUMBO_MAX)
  ) u_classify (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .done_i  (frame_done_i),
    .frame_i (frame_info_i),
    .sym_i   (sym_now),
    .cfg_i   (cfg),
    .inc_o   (inc)
  );

  // Counter bank, cleared by the read that returns it
  for (genvar g = 0; g < NUM_CNT; g++)
  begin : g_cnt
    localparam int W = cnt_width(g);
    logic [W-1:0] raw;

    assign rd_hit[g]  = addr_is(s_axi_araddr_i, CNT_ADDR[g]);
    assign cnt_val[g] = 32'(raw);

    rfs_sat_counter #(
      .W (W)
    ) u_cnt (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .inc_i   (inc[g]),
      .clr_i   (ar_fire && rd_hit[g]),
      .count_o (raw)
    );
  end

  wr_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_go |=> (bvalid_reg && !awready_reg && !wready_reg))
    else $error("write not answered next cycle");

  rd_answer_a: assert property (@(posedge clk_i) disable iff (rst_i)
    ar_fire |=> (s_axi_rvalid_o && s_axi_rdata_o == $past(rd_mux)))
    else $error("read data not returned next cycle");

  rd_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (s_axi_rvalid_o && !s_axi_rready_i) |=> (s_axi_rvalid_o && $stable(s_axi_rdata_o)))
    else $error("read data dropped before taken");

  small_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ar_fire && rd_hit[IDX_FCS]) |=> (s_axi_rdata_o[31:10] == 22'h000000))
    else $error("reserved bits of small counter not zero");

  res_width_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ar_fire && rd_hit[IDX_RES]) |=> (s_axi_rdata_o[31:18] == 14'h0000))
    else $error("reserved bits of resource counter not zero");

  cnt_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ar_fire && rd_hit[IDX_SYM] && !inc[IDX_SYM]) |=> (cnt_val[IDX_SYM] == 32'h00000000))
    else $error("symbol counter not cleared by read");

  sym_frame_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (frame_done_i && sym_now) |-> ##1 inc[IDX_SYM] ##1 !sym_seen_reg || frame_active_i)
    else $error("symbol error frame lost");

  jumbo_cfg_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (frame_done_i && !cfg.jumbo && frame_info_i.len > 14'h0600) |=> !inc[IDX_LARGE])
    else $error("large count past ceiling without jumbo");

  wr_busy_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (bvalid_reg && !s_axi_bready_i) |=> (bvalid_reg && !awready_reg && !wready_reg))
    else $error("write channel reopened before answer taken");

  wr_ro_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_go && !wr_cfg_hit) |=> (bresp_reg == RESP_SLVERR && $stable(cfg_reg)))
    else $error("write to read-only place not refused");

  cfg_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_go && wr_cfg_hit) |=> (cfg_reg == $past(cfg_next)))
    else $error("config write lost");

  rd_err_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ar_fire && !rd_any_hit)
    |=> (s_axi_rresp_o == RESP_SLVERR && s_axi_rdata_o == 32'h00000000))
    else $error("unmapped read not refused");

  sym_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (rxer_sync_reg && frame_active_i && !frame_done_i) |=> sym_seen_reg)
    else $error("receive error during frame not held");

endmodule
`default_nettype wire

// >>> dv/rfs_phy_model.sv
`timescale 1ns/10ps
`default_nettype none
module rfs_phy_model
  import rfs_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Frame request
  input  wire logic       start_i,
  input  wire rfs_frame_s info_i,
  input  wire logic       err_i,
  input  wire logic [3:0] act_len_i,
  output logic            busy_o,
  // Receive status toward the block
  output logic            frame_active_o,
  output logic            frame_done_o,
  output rfs_frame_s      frame_info_o,
  output logic            phy_err_o
);
  rfs_frame_s held_reg;
  logic       err_reg;
  logic       run_reg;
  logic [3:0] cnt_reg;

  assign busy_o         = run_reg;
  assign frame_active_o = run_reg;
  // Error pin only inside a frame
  assign phy_err_o      = run_reg & err_reg;

  always_ff @(posedge clk_i)
  begin
    frame_done_o <= 1'b0;
    // Status is not held outside the done cycle
    frame_info_o <= ~frame_info_o;
    if (rst_i)
    begin
      run_reg      <= 1'b0;
      frame_info_o <= '0;
    end
    else if (start_i && !run_reg)
    begin
      run_reg  <= 1'b1;
      held_reg <= info_i;
      err_reg  <= err_i;
      cnt_reg  <= act_len_i;
    end
    else if (run_reg && cnt_reg == 4'h0)
    begin
      run_reg      <= 1'b0;
      frame_done_o <= 1'b1;
      frame_info_o <= held_reg;
    end
    else if (run_reg)
      cnt_reg <= cnt_reg - 4'h1;
  end
endmodule
`default_nettype wire

// >>> dv/tb_rx_frame_statistics_counters.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      failures++; \
      $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end \
  end
module tb_rx_frame_statistics_counters
  import rfs_pkg::*;
();
  localparam logic [13:0] JMAX = 14'h0c00;
  logic        clk_i, rst_i, start, perr, busy, fact, fdone, pin;
  logic [31:0] awaddr, wdata, araddr, rdata, cfg;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp;
  logic [3:0]  alen;
  rfs_frame_s  info, fi;
  int          failures, comparisons;
  longint      m [NUM_CNT];
  int          wid [NUM_CNT] = '{32, 10, 10, 10, 10, 10, 10, 10, 18};
  int          lens [10] = '{20, 63, 64, 1000, 1518, 1519, 1536, 1600, 3000, 3100};
  logic [31:0] cfgs [6] = '{32'h00000002, 32'h00000102, 32'h0000000a,
                            32'h00010002, 32'h04010100, 32'h0401010a};

  rfs_rx_stats #(.JUMBO_MAX(JMAX)) i_rfs_rx_stats (
    .clk_i(clk_i), .rst_i(rst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .frame_active_i(fact),
    .frame_done_i(fdone), .frame_info_i(fi), .phy_receive_error_input_i(pin));

  rfs_phy_model i_rfs_phy_model (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(start), .info_i(info), .err_i(perr),
    .act_len_i(alen), .busy_o(busy), .frame_active_o(fact), .frame_done_o(fdone),
    .frame_info_o(fi), .phy_err_o(pin));

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic results;
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 60)
    begin
      failures++;
      $display("[FAIL] wait expected done seen timeout");
      results;
    end
  endtask

  task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    bit ad, wd;
    @(posedge clk_i);
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1;
    ad = 0; wd = 0;
    for (n = 0; n < 60 && !(ad && wd); n++)
    begin
      @(posedge clk_i);
      if (awvalid && awready) begin ad = 1; awvalid <= 1'b0; end
      if (wvalid && wready) begin wd = 1; wvalid <= 1'b0; end
    end
    tmo(n);
    repeat ($urandom_range(0, 2)) @(posedge clk_i);
    bready <= 1'b1;
    for (n = 0; n < 60; n++)
    begin
      @(posedge clk_i);
      if (bvalid) break;
    end
    tmo(n);
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask

  task automatic rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk_i);
    araddr <= a; arvalid <= 1'b1;
    for (n = 0; n < 60; n++)
    begin
      @(posedge clk_i);
      if (arready) break;
    end
    tmo(n);
    arvalid <= 1'b0;
    repeat ($urandom_range(0, 2)) @(posedge clk_i);
    rready <= 1'b1;
    for (n = 0; n < 60; n++)
    begin
      @(posedge clk_i);
      if (rvalid) break;
    end
    tmo(n);
    d = rdata; r = rresp;
    rready <= 1'b0;
  endtask

  function automatic void bump(input int i);
    if (m[i] < (longint'(1) << wid[i]) - 1) m[i]++;
  endfunction

  // Reference classification of one frame
  function automatic void model(input rfs_frame_s f, input bit s);
    int  mx, l;
    bit  e, ok;
    mx = cfg[CFG_BIG_BIT] ? 1536 : 1518;
    l = int'(f.len); e = f.crc_bad | s; ok = l >= 64 && l <= mx;
    if (!e && !f.pause && f.copied && l >= 1519 && l <= (cfg[CFG_JUMBO_BIT] ? int'(JMAX) : mx))
      bump(IDX_LARGE);
    if (cfg[CFG_FD_BIT] && l < 64 && !e) bump(IDX_UNDER);
    if (l > mx) bump(e ? IDX_JAB : IDX_OVER);
    if (ok && e) bump(f.dribble ? IDX_ALIGN : IDX_FCS);
    if (ok && e && f.dribble) bump(IDX_RES);
    if (cfg[CFG_LENCHK_BIT] && f.len_field < 16'h0600 && l <= mx && l - 18 < int'(f.len_field))
      bump(IDX_LEN);
    if (s) bump(IDX_SYM);
  endfunction

  task automatic send(input rfs_frame_s f, input bit s);
    int n;
    @(posedge clk_i);
    start <= 1'b1; info <= f; perr <= s; alen <= 4'($urandom_range(3, 8));
    @(posedge clk_i);
    start <= 1'b0;
    for (n = 0; n < 60; n++)
    begin
      @(posedge clk_i);
      if (!busy) break;
    end
    tmo(n);
    model(f, s);
  endtask

  task automatic check_all;
    logic [31:0] d;
    logic [1:0]  r;
    repeat (4) @(posedge clk_i);
    for (int i = 0; i < NUM_CNT; i++)
    begin
      rd(CNT_ADDR[i], d, r);
      `CHK("counter", 32'(m[i]), d)
      `CHK("rresp", RESP_OKAY, r)
      m[i] = 0;
    end
  endtask

  initial
  begin
    rfs_frame_s  f;
    logic [31:0] d;
    logic [1:0]  r;
    bit          s;
    int          l;
    rst_i = 1'b1; start = 1'b0; perr = 1'b0; alen = 4'h3; info = '0; cfg = '0;
    awaddr = '0; wdata = '0; araddr = '0; awvalid = 1'b0; wvalid = 1'b0;
    bready = 1'b0; arvalid = 1'b0; rready = 1'b0; failures = 0; comparisons = 0;
    foreach (m[i]) m[i] = 0;
    void'($urandom(91));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    check_all;
    // Counters refuse writes, unmapped place answers an error
    wr(CNT_ADDR[IDX_FCS], 32'h000003ff, RESP_SLVERR);
    rd(32'h400341a4, d, r);
    `CHK("unmapped data", 32'h0, d)
    `CHK("unmapped resp", RESP_SLVERR, r)
    foreach (cfgs[c])
    begin
      wr(ADDR_CFG, cfgs[c], RESP_OKAY);
      cfg = cfgs[c];
      rd(ADDR_CFG, d, r);
      `CHK("config", cfgs[c] & CFG_MASK, d)
      repeat (40)
      begin
        l = lens[$urandom_range(0, 9)];
        f.len = 14'(l);
        f.len_field = 16'(l > 1518 ? $urandom_range(0, l - 19) : $urandom_range(0, 1600));
        f.crc_bad = 1'($urandom);
        s = l >= 64 && $urandom_range(0, 3) == 0;
        f.dribble = 1'($urandom) & (f.crc_bad | s);
        f.pause = 1'($urandom);
        f.copied = 1'($urandom);
        send(f, s);
      end
      check_all;
      check_all;
    end
    // Undersize count runs into its ceiling
    wr(ADDR_CFG, 32'h00000002, RESP_OKAY);
    cfg = 32'h00000002;
    f = '0;
    f.len = 14'd20;
    repeat (1030) send(f, 1'b0);
    check_all;
    results;
  end
endmodule
`undef CHK
`default_nettype wire
